// [rtl/aidpc_pkg.sv]
// Purpose: shared constants and types for the aiding packet payload codec
// Assumes: payload bytes are little endian, byte 0 of the payload sent first
// Notes:   singles are IEEE fp32 or u32 words, doubles are IEEE fp64 words
package aidpc_pkg;

	// ==========================================================
	// packet identifiers
	localparam logic [7:0] ID_POS_VEL   = 8'h2C;
	localparam logic [7:0] ID_POS       = 8'h2D;
	localparam logic [7:0] ID_VEL       = 8'h2E;
	localparam logic [7:0] ID_BODY_VEL  = 8'h2F;
	localparam logic [7:0] ID_HEADING   = 8'h30;
	localparam logic [7:0] ID_RUN_TIME  = 8'h31;
	localparam logic [7:0] ID_MAG_FIELD = 8'h32;

	// ==========================================================
	// fixed payload lengths in bytes
	localparam logic [7:0] LEN_POS_VEL   = 8'h3C;
	localparam logic [7:0] LEN_POS       = 8'h24;
	localparam logic [7:0] LEN_VEL       = 8'h18;
	localparam logic [7:0] LEN_BODY_VEL  = 8'h10;
	localparam logic [7:0] LEN_HEADING   = 8'h08;
	localparam logic [7:0] LEN_RUN_TIME  = 8'h08;
	localparam logic [7:0] LEN_MAG_FIELD = 8'h0C;
	localparam logic [7:0] LEN_NONE      = 8'h00;

	// ==========================================================
	// payload layout
	localparam int PAYLOAD_MAX   = 60;
	localparam int IMG_BITS      = PAYLOAD_MAX * 8;
	localparam int NUM_DBL       = 3;
	localparam int NUM_SGL       = 9;
	localparam int DBL_BYTES     = 8;
	localparam int SGL_BYTES     = 4;
	// singles start after the three doubles, or at byte 0 when there are none
	localparam int SGL_BASE_DBL  = 24;
	localparam int SGL_BASE_NONE = 0;
	localparam int FIFO_DEPTH    = 16;
	localparam int FIFO_WIDTH    = 9;

	typedef struct packed {
		logic [NUM_DBL-1:0][63:0] dbl;
		logic [NUM_SGL-1:0][31:0] sgl;
	} aidpc_fields_type;

	typedef struct packed {
		logic [7:0]       id;
		aidpc_fields_type f;
	} aidpc_req_type;

	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} aidpc_byte_type;

	function automatic logic [7:0] len_of(input logic [7:0] id);
		case (id)
			ID_POS_VEL:   len_of = LEN_POS_VEL;
			ID_POS:       len_of = LEN_POS;
			ID_VEL:       len_of = LEN_VEL;
			ID_BODY_VEL:  len_of = LEN_BODY_VEL;
			ID_HEADING:   len_of = LEN_HEADING;
			ID_RUN_TIME:  len_of = LEN_RUN_TIME;
			ID_MAG_FIELD: len_of = LEN_MAG_FIELD;
			default:      len_of = LEN_NONE;
		endcase
	endfunction

	function automatic logic has_dbl(input logic [7:0] id);
		has_dbl = (id == ID_POS_VEL) || (id == ID_POS);
	endfunction

endpackage

// [rtl/aidpc_fifo.sv]
// Purpose: byte FIFO between payload packer and the framer
// Assumes: one clock, DEPTH a power of two
// Notes:   first-word-fall-through, output word read straight from storage
`timescale 1ns/10ps
`default_nettype none
module aidpc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	// ==========================================================
	// flags
	assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
	                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_reg[AW-1:0]];

	// ==========================================================
	// storage and pointers
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule
`default_nettype wire

// [rtl/aidpc_host.sv]
// Purpose: host side packer and unpacker of aiding packet payloads, ids 44 to 50
// Assumes: framer adds header and checksum; rx_id stable for a whole payload
// Notes:   payload bytes go out through a 16 word FIFO with back-pressure
`timescale 1ns/10ps
`default_nettype none
module aidpc_host #(
	parameter int FIFO_DEPTH = aidpc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// packing request
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire aidpc_pkg::aidpc_req_type  req,
	output logic                           req_bad,
	// outgoing payload bytes to framer
	output logic                           tx_valid,
	input  wire logic                      tx_ready,
	output logic [7:0]                     tx_byte,
	output logic                           tx_last,
	output logic [7:0]                     tx_id,
	output logic [7:0]                     tx_len,
	// incoming payload bytes from deframer
	input  wire logic                      rx_valid,
	input  wire logic [7:0]                rx_byte,
	input  wire logic                      rx_last,
	input  wire logic [7:0]                rx_id,
	// decoded fields
	output aidpc_pkg::aidpc_fields_type    rx_fields,
	output logic [7:0]                     rx_pkt_id,
	output logic                           rx_update,
	output logic                           rx_drop
);
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} aidpc_tx_state_type;

	aidpc_tx_state_type            tx_state_reg;
	logic [aidpc_pkg::IMG_BITS-1:0] image_reg;
	logic [7:0]                    idx_reg;
	logic [7:0]                    tx_id_reg;
	logic [7:0]                    tx_len_reg;
	logic                          req_bad_reg;
	logic                          req_take;
	logic                          fifo_in_valid;
	logic                          fifo_in_ready;
	logic                          fifo_push;
	logic                          push_last;
	aidpc_pkg::aidpc_byte_type     fifo_in;
	aidpc_pkg::aidpc_byte_type     fifo_out;

	// ==========================================================
	// payload image builders
	function automatic logic [aidpc_pkg::IMG_BITS-1:0] pack_image(
		input aidpc_pkg::aidpc_req_type r);
		logic [aidpc_pkg::IMG_BITS-1:0] img;
		int                             base;
		int                             len;
		img  = '0;
		len  = int'(aidpc_pkg::len_of(r.id));
		base = aidpc_pkg::SGL_BASE_NONE;
		if (aidpc_pkg::has_dbl(r.id)) begin
			base = aidpc_pkg::SGL_BASE_DBL;
			for (int i = 0; i < aidpc_pkg::NUM_DBL; i++) begin
				img[i*aidpc_pkg::DBL_BYTES*8 +: 64] = r.f.dbl[i];
			end
		end
		// singles packed at stride 4, so the third field of id 50 lands at 8
		for (int i = 0; i < aidpc_pkg::NUM_SGL; i++) begin
			if (base + (i + 1) * aidpc_pkg::SGL_BYTES <= len) begin
				img[(base + i*aidpc_pkg::SGL_BYTES)*8 +: 32] = r.f.sgl[i];
			end
		end
		return img;
	endfunction

	function automatic aidpc_pkg::aidpc_fields_type unpack_image(
		input logic [aidpc_pkg::IMG_BITS-1:0] img,
		input logic [7:0]                     id);
		aidpc_pkg::aidpc_fields_type f;
		int                          base;
		int                          len;
		f    = '0;
		len  = int'(aidpc_pkg::len_of(id));
		base = aidpc_pkg::SGL_BASE_NONE;
		if (aidpc_pkg::has_dbl(id)) begin
			base = aidpc_pkg::SGL_BASE_DBL;
			for (int i = 0; i < aidpc_pkg::NUM_DBL; i++) begin
				f.dbl[i] = img[i*aidpc_pkg::DBL_BYTES*8 +: 64];
			end
		end
		for (int i = 0; i < aidpc_pkg::NUM_SGL; i++) begin
			if (base + (i + 1) * aidpc_pkg::SGL_BYTES <= len) begin
				f.sgl[i] = img[(base + i*aidpc_pkg::SGL_BYTES)*8 +: 32];
			end
		end
		return f;
	endfunction

	// ==========================================================
	// transmit packer
	assign req_ready     = (tx_state_reg == TX_IDLE);
	assign req_take      = req_valid && req_ready;
	assign fifo_in_valid = (tx_state_reg == TX_SEND);
	assign fifo_push     = fifo_in_valid && fifo_in_ready;
	assign push_last     = (idx_reg == tx_len_reg - 8'h01);
	assign fifo_in.data  = image_reg[7:0];
	assign fifo_in.last  = push_last;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= TX_IDLE;
		end else begin
			case (tx_state_reg)
				TX_IDLE: begin
					if (req_take && aidpc_pkg::len_of(req.id) != aidpc_pkg::LEN_NONE) begin
						tx_state_reg <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (fifo_push && push_last) begin
						tx_state_reg <= TX_IDLE;
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// shifting the image keeps the byte mux off a 60 way select
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			image_reg <= '0;
			idx_reg   <= 8'h00;
		end else if (req_take) begin
			image_reg <= pack_image(req);
			idx_reg   <= 8'h00;
		end else if (fifo_push) begin
			image_reg <= image_reg >> 8;
			idx_reg   <= idx_reg + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_id_reg  <= 8'h00;
			tx_len_reg <= 8'h00;
		end else if (req_take && aidpc_pkg::len_of(req.id) != aidpc_pkg::LEN_NONE) begin
			tx_id_reg  <= req.id;
			tx_len_reg <= aidpc_pkg::len_of(req.id);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_bad_reg <= 1'b0;
		end else begin
			req_bad_reg <= req_take && (aidpc_pkg::len_of(req.id) == aidpc_pkg::LEN_NONE);
		end
	end

	assign req_bad = req_bad_reg;
	assign tx_id   = tx_id_reg;
	assign tx_len  = tx_len_reg;
	assign tx_byte = fifo_out.data;
	assign tx_last = fifo_out.last;

	aidpc_fifo #(
		.WIDTH (aidpc_pkg::FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (fifo_out)
	);

	// ==========================================================
	// receive unpacker
	logic [7:0]                     rx_buf [0:aidpc_pkg::PAYLOAD_MAX-1];
	logic [aidpc_pkg::IMG_BITS-1:0] rx_img;
	logic [7:0]                     rx_cnt_reg;
	logic                           rx_done_reg;
	logic [7:0]                     rx_done_id_reg;
	logic [7:0]                     rx_done_len_reg;
	logic                           rx_len_ok;
	aidpc_pkg::aidpc_fields_type    rx_fields_reg;
	logic [7:0]                     rx_pkt_id_reg;
	logic                           rx_update_reg;
	logic                           rx_drop_reg;

	genvar g;
	generate
		for (g = 0; g < aidpc_pkg::PAYLOAD_MAX; g++) begin : g_img
			assign rx_img[g*8 +: 8] = rx_buf[g];
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rx_valid && rx_cnt_reg < 8'(aidpc_pkg::PAYLOAD_MAX)) begin
			rx_buf[rx_cnt_reg[5:0]] <= rx_byte;
		end
	end

	// count saturates so an overlong payload never aliases a valid length
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_reg <= 8'h00;
		end else if (rx_valid && rx_last) begin
			rx_cnt_reg <= 8'h00;
		end else if (rx_valid && rx_cnt_reg != 8'hFF) begin
			rx_cnt_reg <= rx_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_done_reg     <= 1'b0;
			rx_done_id_reg  <= 8'h00;
			rx_done_len_reg <= 8'h00;
		end else begin
			rx_done_reg <= rx_valid && rx_last;
			if (rx_valid && rx_last) begin
				rx_done_id_reg  <= rx_id;
				rx_done_len_reg <= (rx_cnt_reg == 8'hFF) ? 8'hFF : rx_cnt_reg + 8'h01;
			end
		end
	end

	assign rx_len_ok = (aidpc_pkg::len_of(rx_done_id_reg) != aidpc_pkg::LEN_NONE) &&
	                   (rx_done_len_reg == aidpc_pkg::len_of(rx_done_id_reg));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_fields_reg <= '0;
			rx_pkt_id_reg <= 8'h00;
		end else if (rx_done_reg && rx_len_ok) begin
			rx_fields_reg <= unpack_image(rx_img, rx_done_id_reg);
			rx_pkt_id_reg <= rx_done_id_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_update_reg <= 1'b0;
			rx_drop_reg   <= 1'b0;
		end else begin
			rx_update_reg <= rx_done_reg && rx_len_ok;
			rx_drop_reg   <= rx_done_reg && !rx_len_ok;
		end
	end

	assign rx_fields = rx_fields_reg;
	assign rx_pkt_id = rx_pkt_id_reg;
	assign rx_update = rx_update_reg;
	assign rx_drop   = rx_drop_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	pos_vel_len_a: assert property (
		req_take && req.id == aidpc_pkg::ID_POS_VEL |=>
			tx_len == 8'h3C && tx_state_reg == TX_SEND)
		else $error("id 44 length not 60");

	pos_vel_map_a: assert property (
		req_take && req.id == aidpc_pkg::ID_POS_VEL |=>
			image_reg[63:0] == $past(req.f.dbl[0]) &&
			image_reg[24*8 +: 32] == $past(req.f.sgl[0]) &&
			image_reg[56*8 +: 32] == $past(req.f.sgl[8]))
		else $error("id 44 field placement wrong");

	pos_len_a: assert property (
		req_take && req.id == aidpc_pkg::ID_POS |=> tx_len == 8'h24)
		else $error("id 45 length not 36");

	pos_map_a: assert property (
		req_take && req.id == aidpc_pkg::ID_POS |=>
			image_reg[16*8 +: 64] == $past(req.f.dbl[2]) &&
			image_reg[32*8 +: 32] == $past(req.f.sgl[2]) &&
			image_reg[479:288] == '0)
		else $error("id 45 field placement wrong");

	vel_map_a: assert property (
		req_take && req.id == aidpc_pkg::ID_VEL |=> tx_len == 8'h18 &&
			image_reg[12*8 +: 32] == $past(req.f.sgl[3]) &&
			image_reg[20*8 +: 32] == $past(req.f.sgl[5]))
		else $error("id 46 layout wrong");

	body_vel_a: assert property (
		req_take && req.id == aidpc_pkg::ID_BODY_VEL |=> tx_len == 8'h10 &&
			image_reg[12*8 +: 32] == $past(req.f.sgl[3]) && image_reg[479:128] == '0)
		else $error("id 47 layout wrong");

	heading_map_a: assert property (
		req_take && req.id == aidpc_pkg::ID_HEADING |=> tx_len == 8'h08 &&
			image_reg[63:32] == $past(req.f.sgl[1]))
		else $error("id 48 layout wrong");

	run_time_a: assert property (
		req_take && req.id == aidpc_pkg::ID_RUN_TIME |=> tx_len == 8'h08 &&
			image_reg[31:0] == $past(req.f.sgl[0]))
		else $error("id 49 layout wrong");

	mag_field_a: assert property (
		req_take && req.id == aidpc_pkg::ID_MAG_FIELD |=> tx_len == 8'h0C &&
			image_reg[95:64] == $past(req.f.sgl[2]) && image_reg[479:96] == '0)
		else $error("id 50 Z not at byte 8");

	push_count_a: assert property (
		fifo_push && fifo_in.last |->
			idx_reg + 8'h01 == aidpc_pkg::len_of(tx_id) ##1 req_ready)
		else $error("payload byte count wrong");

	rx_bad_len_a: assert property (
		rx_done_reg && !rx_len_ok |=> rx_drop && !rx_update && $stable(rx_fields))
		else $error("bad length payload not dropped");

	pos_vel_sent_c: cover property (
		fifo_push && fifo_in.last && tx_id == aidpc_pkg::ID_POS_VEL);
	mag_sent_c:     cover property (
		fifo_push && fifo_in.last && tx_id == aidpc_pkg::ID_MAG_FIELD);
	fifo_full_c:    cover property (fifo_in_valid && !fifo_in_ready);
	rx_update_c:    cover property (rx_update);
	rx_drop_c:      cover property (rx_drop);

endmodule
`default_nettype wire

// [sim/aidpc_dev_model.sv]
// Purpose: behavioural navigation module at the far side of the payload codec
// Assumes: one byte a cycle each way, tx_ready stalls drawn at random
// Notes:   rx_byte and rx_id show the inverse of the last value between frames, rx_valid and rx_last drop to 0
`timescale 1ns/10ps
`default_nettype none
module aidpc_dev_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// payload bytes from the codec
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_last,
	// stall control
	input  wire logic       hold,
	// payload bytes to the codec
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_last,
	output logic [7:0]      rx_id
);
	integer     seed = 32'h5C1F222B;
	logic [8:0] cap[$];

	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_byte  = 8'h00;
		rx_last  = 1'b0;
		rx_id    = 8'h00;
	end

	// ==========================================================
	// device receive side, stalls as a busy core would
	always @(posedge core_clk) begin
		tx_ready <= !hold && ($random(seed) % 4 != 0);
		if (rst_n && tx_valid && tx_ready) begin
			cap.push_back({tx_last, tx_byte});
		end
	end

	// ==========================================================
	// device send side, lsb of each field first
	task automatic send(input logic [7:0] id, input int n, input logic [479:0] d);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_byte  <= d[8*i +: 8];
			rx_last  <= (i == n - 1);
			rx_id    <= id;
		end
	endtask

	// released lines must not keep the old value
	task automatic idle();
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
		rx_byte  <= ~rx_byte;
		rx_id    <= ~rx_id;
	endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Purpose: self-checking bench of the host payload codec
// Assumes: partner model stalls at random, fixed seed
// Notes:   expected images built from the layout tables here
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                        core_clk  = 1'b0;
	logic                        rst_n     = 1'b0;
	logic                        req_valid = 1'b0;
	logic                        hold      = 1'b0;
	aidpc_pkg::aidpc_req_type    req       = '0;
	logic                        req_ready, req_bad, tx_valid, tx_ready, tx_last;
	logic                        rx_valid, rx_last, rx_update, rx_drop;
	logic [7:0]                  tx_byte, tx_id, tx_len, rx_byte, rx_id, rx_pkt_id, id, kid;
	aidpc_pkg::aidpc_fields_type rx_fields, f, keep;
	logic [479:0]                d;
	integer                      seed = 32'h5C1F222B;
	int                          fails = 0;
	int                          n_compared = 0;

	always #25 core_clk = ~core_clk;

	aidpc_host i_aidpc_host (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .req_bad(req_bad), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last), .tx_id(tx_id),
		.tx_len(tx_len), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
		.rx_id(rx_id), .rx_fields(rx_fields), .rx_pkt_id(rx_pkt_id),
		.rx_update(rx_update), .rx_drop(rx_drop));
	aidpc_dev_model i_aidpc_dev_model (.core_clk(core_clk), .rst_n(rst_n),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last),
		.hold(hold), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
		.rx_id(rx_id));

	// ==========================================================
	// expectations
	function automatic int exp_len(input logic [7:0] i);
		case (i)
			8'h2C:   return 60;
			8'h2D:   return 36;
			8'h2E:   return 24;
			8'h2F:   return 16;
			8'h30:   return 8;
			8'h31:   return 8;
			8'h32:   return 12;
			default: return 0;
		endcase
	endfunction
	// singles follow the doubles only in the two position messages
	function automatic int base_of(input logic [7:0] i);
		return (i == 8'h2C || i == 8'h2D) ? 24 : 0;
	endfunction
	function automatic logic [479:0] img(input logic [7:0] i, input aidpc_pkg::aidpc_fields_type v);
		logic [479:0] m;
		m = '0;
		for (int j = 0; j < 3 && base_of(i) != 0; j++) begin
			m[64*j +: 64] = v.dbl[j];
		end
		for (int k = 0; base_of(i) + 4*k + 4 <= exp_len(i); k++) begin
			m[8*(base_of(i) + 4*k) +: 32] = v.sgl[k];
		end
		return m;
	endfunction
	function automatic aidpc_pkg::aidpc_fields_type fld(input logic [7:0] i, input logic [479:0] m);
		aidpc_pkg::aidpc_fields_type r;
		r = '0;
		for (int j = 0; j < 3 && base_of(i) != 0; j++) begin
			r.dbl[j] = m[64*j +: 64];
		end
		for (int k = 0; base_of(i) + 4*k + 4 <= exp_len(i); k++) begin
			r.sgl[k] = m[8*(base_of(i) + 4*k) +: 32];
		end
		return r;
	endfunction

	// ==========================================================
	// compares and drivers
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chkf(input string what, input aidpc_pkg::aidpc_fields_type e,
		input aidpc_pkg::aidpc_fields_type g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic pack(input logic [7:0] i, input aidpc_pkg::aidpc_fields_type v);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req       <= {i, v};
		for (int n = 0; n < 200; n++) begin
			#1;
			if (req_ready === 1'b1) break;
			@(posedge core_clk);
		end
		// a packer that never frees up counts against the run
		if (req_ready !== 1'b1) begin
			fails++;
			$display("CHECK FAILED req_ready expected 1 seen %b", req_ready);
		end
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask
	// pulse stands one cycle, just after the edge that follows the rx_last edge
	task automatic result(input logic upd, input logic [7:0] i, input aidpc_pkg::aidpc_fields_type e);
		repeat (2) @(posedge core_clk);
		#1;
		chk("rx_update", upd, rx_update);
		chk("rx_drop", !upd, rx_drop);
		chk("rx_pkt_id", i, rx_pkt_id);
		chkf("rx_fields", e, rx_fields);
	endtask
	task automatic bad(input logic [7:0] i, input int n);
		i_aidpc_dev_model.send(i, n, d);
		fork
			i_aidpc_dev_model.idle();
			result(1'b0, kid, keep);
		join
	endtask
	task automatic finish_test();
		$display("TB: %0d compared, %0d failed", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		fails++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		keep = '0;
		kid  = 8'h00;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int n = 0; n < 8; n++) begin
			id = (n == 7) ? 8'h33 : 8'h2C + n[7:0];
			for (int w = 0; w < 15; w++) begin
				d[32*w +: 32] = $random(seed);
			end
			f = d;
			i_aidpc_dev_model.cap.delete();
			if (n == 0) begin
				fork
					pack(id, f);
					begin
						@(posedge core_clk);
						hold <= 1'b1;
						repeat (40) @(posedge core_clk);
						#1;
						chk("fifo_full_valid", 1, tx_valid);
						chk("fifo_full_ready", 0, req_ready);
						@(posedge core_clk);
						hold <= 1'b0;
					end
				join
			end else begin
				pack(id, f);
			end
			if (n == 7) begin
				// req_bad stands only in the cycle right after the take
				#1;
				chk("req_bad", 1, req_bad);
				repeat (20) @(posedge core_clk);
				chk("tx_none", 0, i_aidpc_dev_model.cap.size());
				continue;
			end
			for (int c = 0; c < 400; c++) begin
				@(posedge core_clk);
				#1;
				if (i_aidpc_dev_model.cap.size() > 0 && i_aidpc_dev_model.cap[$][8]) break;
			end
			chk("tx_valid_drained", 0, tx_valid);
			d = img(id, f);
			chk("tx_count", exp_len(id), i_aidpc_dev_model.cap.size());
			foreach (i_aidpc_dev_model.cap[b]) begin
				chk("tx_byte", {b == exp_len(id) - 1, d[8*b +: 8]}, i_aidpc_dev_model.cap[b]);
			end
			chk("tx_id", id, tx_id);
			chk("tx_len", exp_len(id), tx_len);
			i_aidpc_dev_model.send(id, exp_len(id), d);
			fork
				i_aidpc_dev_model.idle();
				result(1'b1, id, fld(id, d));
			join
			keep = fld(id, d);
			kid  = id;
		end
		bad(8'h30, 7);
		bad(8'h32, 16);
		bad(8'h2C, 59);
		bad(8'h33, 8);
		// back to back payloads, no idle cycle between them
		i_aidpc_dev_model.send(8'h2E, 24, img(8'h2E, f));
		fork
			i_aidpc_dev_model.send(8'h2F, 16, img(8'h2F, f));
			result(1'b1, 8'h2E, fld(8'h2E, img(8'h2E, f)));
		join
		fork
			i_aidpc_dev_model.idle();
			result(1'b1, 8'h2F, fld(8'h2F, img(8'h2F, f)));
		join
		finish_test();
	end
endmodule
`default_nettype wire
